/* File: hw/ssipo_pkg.sv */
// Purpose: Shared constants and types for the serial absolute position output
// Assumes: Core clock of 250 MHz
// Notes:   Times are in ns; cycle counts derive from them
package ssipo_pkg;
   localparam int unsigned CLK_PERIOD_NS      = 4;
   localparam int unsigned HOLD_OFF_TIME_NS   = 20000;
   localparam int unsigned HOLD_OFF_MIN_NS    = 10000;
   localparam int unsigned HOLD_OFF_CYC       = HOLD_OFF_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned HOLD_OFF_MIN_CYC   = (HOLD_OFF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned POS_W_DEF          = 13;
   localparam int unsigned WORD_BITS_RING     = 25;
   localparam int unsigned RING_MAX_BITS      = 13;
   localparam logic        DATA_IDLE_LEVEL    = 1'b1;
   localparam logic        SPECIAL_RESET_VAL  = 1'b0;

   typedef enum logic [1:0] {
      SSIPO_IDLE,
      SSIPO_SHIFT,
      SSIPO_HOLD
   } ssipo_state_t;

   // Link clock edge strobes after synchronisation
   typedef struct packed {
      logic clk_fall;
      logic clk_rise;
   } ssipo_link_t;
endpackage

/* File: hw/ssipo_top.sv */
// Purpose: Encoder-side serial output: capture, shift, hold-off, ring repeat
// Assumes: Link clock sampled on clk; bursts spaced beyond the hold-off time
// Notes:   Word is special bit then position, sent MSB first
`timescale 1ns/1ns
`default_nettype none
module ssipo_top
   import ssipo_pkg::*;
#(
   parameter int unsigned POS_W        = POS_W_DEF,
   parameter bit          GRAY_OUT     = 1'b1,
   parameter int unsigned HOLD_CYC     = HOLD_OFF_CYC
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             clk_en,
   // Position source
   input  wire logic [POS_W-1:0] pos_raw,
   input  wire logic             special_bit,
   input  wire logic             dir_sel_n,
   // Serial link
   input  wire logic             link_clk,
   output var  logic             data_out,
   output var  logic             busy
);
   localparam int unsigned WW   = POS_W + 1;
   localparam int unsigned CW   = $clog2(WORD_BITS_RING + 2);
   localparam int unsigned TW   = $clog2(HOLD_CYC + 2);
   localparam logic [TW-1:0] HOLD_N = TW'(HOLD_CYC);
   localparam logic [CW-1:0] RING_N = CW'(WORD_BITS_RING);
   localparam bit RING_OK = (POS_W <= RING_MAX_BITS);

   logic [2:0]      lk_sync_r;
   logic [WW-1:0]   word_r;
   logic [WW-1:0]   shift_r;
   logic [CW-1:0]   bit_cnt_r;
   logic [TW-1:0]   tmr_r;
   logic            data_r;
   logic            busy_r;
   ssipo_state_t    state_r;
   ssipo_link_t     lk;

   // Two-stage sync, then edge detect on stages two and three
   assign lk.clk_fall = lk_sync_r[2] & ~lk_sync_r[1];
   assign lk.clk_rise = ~lk_sync_r[2] & lk_sync_r[1];

   // Direction and code conversion
   wire logic [POS_W-1:0] pos_dir  = dir_sel_n ? pos_raw : ~pos_raw;
   wire logic [POS_W-1:0] pos_code = GRAY_OUT ? (pos_dir ^ (pos_dir >> 1)) : pos_dir;
   wire logic [WW-1:0]    fresh    = {special_bit, pos_code};
   wire logic             tmr_done = (tmr_r == '0);
   wire logic             last_bit = (bit_cnt_r == CW'(WW));
   wire logic             ring_end = (bit_cnt_r == RING_N);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lk_sync_r <= 3'h7;
      end else if (clk_en) begin
         lk_sync_r <= {lk_sync_r[1:0], link_clk};
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r   <= SSIPO_IDLE;
         word_r    <= '0;
         shift_r   <= '0;
         bit_cnt_r <= '0;
         tmr_r     <= '0;
         data_r    <= DATA_IDLE_LEVEL;
         busy_r    <= 1'b0;
      end else if (clk_en) begin
         if (lk.clk_fall) begin
            tmr_r <= HOLD_N;
         end else if (!tmr_done) begin
            tmr_r <= tmr_r - TW'(1);
         end
         case (state_r)
            SSIPO_IDLE: begin
               data_r <= DATA_IDLE_LEVEL;
               busy_r <= 1'b0;
               if (lk.clk_fall) begin
                  word_r    <= fresh;
                  shift_r   <= fresh;
                  bit_cnt_r <= '0;
                  busy_r    <= 1'b1;
                  state_r   <= SSIPO_SHIFT;
               end
            end
            SSIPO_SHIFT: begin
               if (lk.clk_rise) begin
                  bit_cnt_r <= bit_cnt_r + CW'(1);
                  if (bit_cnt_r < CW'(WW)) begin
                     data_r  <= shift_r[WW-1];
                     shift_r <= {shift_r[WW-2:0], 1'b0};
                  end else if (RING_OK && ring_end) begin
                     // Start of next word: 26th pulse decides
                     bit_cnt_r <= CW'(1);
                     if (tmr_done) begin
                        word_r  <= fresh;
                        data_r  <= fresh[WW-1];
                        shift_r <= {fresh[WW-2:0], 1'b0};
                     end else begin
                        data_r  <= word_r[WW-1];
                        shift_r <= {word_r[WW-2:0], 1'b0};
                     end
                  end else begin
                     data_r <= 1'b0;
                  end
               end else if (tmr_done && bit_cnt_r >= CW'(WW) && !lk.clk_fall) begin
                  data_r  <= DATA_IDLE_LEVEL;
                  busy_r  <= 1'b0;
                  state_r <= SSIPO_IDLE;
               end else if (tmr_done && last_bit == 1'b0 && bit_cnt_r < CW'(WW)
                            && !lk.clk_fall) begin
                  // Burst abandoned mid-word
                  data_r  <= DATA_IDLE_LEVEL;
                  busy_r  <= 1'b0;
                  state_r <= SSIPO_IDLE;
               end
            end
            default: begin
               state_r <= SSIPO_IDLE;
            end
         endcase
      end
   end

   assign data_out = data_r;
   assign busy     = busy_r;

   // Checks
   property p_idle_high;
      @(posedge clk) disable iff (!resetn)
      (state_r == SSIPO_IDLE && $past(state_r) == SSIPO_IDLE) |-> data_out;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("data not high idle");

   property p_capture;
      @(posedge clk) disable iff (!resetn)
      (clk_en && state_r == SSIPO_IDLE && lk.clk_fall) |=> (word_r == $past(fresh));
   endproperty
   a_capture: assert property (p_capture) else $error("capture wrong");

   property p_msb;
      @(posedge clk) disable iff (!resetn)
      (clk_en && state_r == SSIPO_SHIFT && lk.clk_rise && bit_cnt_r == '0)
         |=> (data_out == word_r[WW-1]);
   endproperty
   a_msb: assert property (p_msb) else $error("msb not first");

   property p_shift;
      @(posedge clk) disable iff (!resetn)
      (clk_en && state_r == SSIPO_SHIFT && lk.clk_rise && bit_cnt_r < CW'(WW))
         |=> (data_out == $past(shift_r[WW-1]));
   endproperty
   a_shift: assert property (p_shift) else $error("shift bit wrong");

   property p_low_after;
      @(posedge clk) disable iff (!resetn)
      (clk_en && state_r == SSIPO_SHIFT && lk.clk_rise && bit_cnt_r == CW'(WW) && !ring_end)
         |=> !data_out;
   endproperty
   a_low_after: assert property (p_low_after) else $error("data not low after lsb");

   property p_timer;
      @(posedge clk) disable iff (!resetn)
      (clk_en && lk.clk_fall) |=> (tmr_r == HOLD_N);
   endproperty
   a_timer: assert property (p_timer) else $error("timer not started");

   property p_stable;
      @(posedge clk) disable iff (!resetn)
      (state_r == SSIPO_SHIFT && !(lk.clk_rise && tmr_done)) |=> $stable(word_r);
   endproperty
   a_stable: assert property (p_stable) else $error("word changed");

   property p_repeat;
      @(posedge clk) disable iff (!resetn)
      (clk_en && state_r == SSIPO_SHIFT && lk.clk_rise && ring_end && RING_OK && !tmr_done)
         |=> (data_out == $past(word_r[WW-1]));
   endproperty
   a_repeat: assert property (p_repeat) else $error("ring repeat wrong");

   property p_release;
      @(posedge clk) disable iff (!resetn)
      (clk_en && state_r == SSIPO_SHIFT && tmr_done && !lk.clk_rise && !lk.clk_fall)
         |=> (data_out && !busy);
   endproperty
   a_release: assert property (p_release) else $error("no release on expiry");

   property p_freeze;
      @(posedge clk) disable iff (!resetn)
      !clk_en |=> ($stable(state_r) && $stable(tmr_r) && $stable(data_r) && $stable(word_r));
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");

   c_burst:   cover property (@(posedge clk) state_r == SSIPO_IDLE ##1 state_r == SSIPO_SHIFT);
   c_return:  cover property (@(posedge clk) state_r == SSIPO_SHIFT ##1 state_r == SSIPO_IDLE);
   c_ring:    cover property (@(posedge clk) lk.clk_rise && ring_end && state_r == SSIPO_SHIFT);
   c_freeze:  cover property (@(posedge clk) !clk_en && state_r == SSIPO_SHIFT);
endmodule
`default_nettype wire

/* File: tb/ssipo_ctrl_model.sv */
// Purpose: Behavioural serial controller that drives clock bursts
// Assumes: Link edges land on falling edges of the core clock
// Notes:   Samples data at the end of each high half-period
`timescale 1ns/1ns
`default_nettype none
module ssipo_ctrl_model #(
   parameter int GAP = 80
) (
   // Core clock
   input  wire logic clk,
   // Serial link
   output var  logic link_clk,
   input  wire logic data_in,
   // Sample report, toggles per bit
   output var  logic smp_stb,
   output var  logic smp_val
);
   initial begin
      link_clk = 1'b1;
      smp_stb  = 1'b0;
      smp_val  = 1'b0;
   end
   // Half period of 24 ns; bit rate scaled up with the shortened hold-off
   task automatic burst(input int n);
      for (int i = 0; i < n; i++) begin
         link_clk = 1'b0;
         repeat (6) @(negedge clk);
         link_clk = 1'b1;
         repeat (6) @(negedge clk);
         smp_val = data_in;
         smp_stb = ~smp_stb;
      end
   endtask
   // Idle gap beyond the hold-off time
   task automatic pause();
      repeat (GAP) @(negedge clk);
   endtask
endmodule
`default_nettype wire

/* File: tb/tb_ssi_absolute_position_output.sv */
// Purpose: Self-checking bench for the serial position output
// Assumes: Short hold-off parameter; controller model drives the link
// Notes:   Expected bits queue up; a watcher compares each sampled bit
`timescale 1ns/1ns
`default_nettype none
module tb_ssi_absolute_position_output;
   import ssipo_pkg::*;
   localparam int unsigned PW = POS_W_DEF;
   localparam int unsigned HC = 50;
   logic          clk, resetn, special_bit, dir_sel_n;
   logic [PW-1:0] pos_raw;
   logic          link_clk, data_out, busy, smp_stb, smp_val;
   logic          clk_en, data_out_b, busy_b;
   logic          exp_q[$];
   logic          exp_b_q[$];
   int            err_count = 0;
   int            cmp_count = 0;
   int            cyc = 0;
   ssipo_top #(.HOLD_CYC(HC)) dut_u (
      .clk(clk), .resetn(resetn), .clk_en(clk_en), .pos_raw(pos_raw),
      .special_bit(special_bit), .dir_sel_n(dir_sel_n), .link_clk(link_clk),
      .data_out(data_out), .busy(busy));
   // Binary-code variant on the same link
   ssipo_top #(.GRAY_OUT(1'b0), .HOLD_CYC(HC)) dut_bin_u (
      .clk(clk), .resetn(resetn), .clk_en(clk_en), .pos_raw(pos_raw),
      .special_bit(special_bit), .dir_sel_n(dir_sel_n), .link_clk(link_clk),
      .data_out(data_out_b), .busy(busy_b));
   ssipo_ctrl_model #(.GAP(HC + 30)) ctl_u (
      .clk(clk), .link_clk(link_clk), .data_in(data_out),
      .smp_stb(smp_stb), .smp_val(smp_val));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (e !== g) begin
         err_count++;
         $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   function automatic logic [PW:0] word_of(logic s, logic [PW-1:0] r, logic d, logic g);
      logic [PW-1:0] c;
      c = d ? r : ~r;
      if (g) c = c ^ (c >> 1);
      return {s, c};
   endfunction
   task automatic push_word(input logic s, input logic [PW-1:0] r, input logic d,
                            input int zeros);
      logic [PW:0] wg;
      logic [PW:0] wb;
      wg = word_of(s, r, d, 1'b1);
      wb = word_of(s, r, d, 1'b0);
      for (int i = PW; i >= 0; i--) begin
         exp_q.push_back(wg[i]);
         exp_b_q.push_back(wb[i]);
      end
      repeat (zeros) begin
         exp_q.push_back(1'b0);
         exp_b_q.push_back(1'b0);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(smp_stb) begin
      if ($time > 0) begin
         chk({15'h0, exp_q.pop_front()}, {15'h0, smp_val});
         chk({15'h0, exp_b_q.pop_front()}, {15'h0, data_out_b});
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 12000) begin
         err_count++;
         end_of_test();
      end
   end
   initial begin
      resetn = 1'b0;
      clk_en = 1'b1;
      pos_raw = '0;
      special_bit = 1'b0;
      dir_sel_n = 1'b1;
      void'($urandom(32'hC399601E));
      repeat (20) @(negedge clk);
      resetn = 1'b1;
      repeat (5) @(negedge clk);
      chk({15'h0, data_out}, 16'h1);
      for (int t = 0; t < 2; t++) begin
         int n;
         dir_sel_n = t[0];
         special_bit = 1'($urandom);
         pos_raw = PW'($urandom);
         push_word(special_bit, pos_raw, dir_sel_n, 1);
         fork
            ctl_u.burst(15);
            begin
               repeat (8) @(negedge clk);
               chk({15'h0, busy}, 16'h1);
               pos_raw = ~pos_raw;
            end
         join
         chk({15'h0, data_out}, 16'h0);
         if (t == 1) begin
            // Frozen clock enable must hold the hold-off phase for 100 cycles, twice the hold-off
            clk_en = 1'b0;
            repeat (100) @(negedge clk);
            chk({15'h0, data_out}, 16'h0);
            chk({15'h0, busy}, 16'h1);
            clk_en = 1'b1;
         end
         n = 0;
         while (data_out !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
         end
         chk({15'h0, n > 30 && n < 60}, 16'h1);
         chk({15'h0, busy}, 16'h0);
         chk({15'h0, busy_b}, 16'h0);
         ctl_u.pause();
         push_word(special_bit, pos_raw, dir_sel_n, 11);
         push_word(special_bit, pos_raw, dir_sel_n, 0);
         fork
            ctl_u.burst(39);
            begin
               repeat (30) @(negedge clk);
               pos_raw = PW'($urandom);
            end
         join
         ctl_u.pause();
         push_word(special_bit, pos_raw, dir_sel_n, 11);
         ctl_u.burst(25);
         ctl_u.pause();
         pos_raw = PW'($urandom);
         push_word(special_bit, pos_raw, dir_sel_n, 1);
         ctl_u.burst(15);
         ctl_u.pause();
         $display("test %0d done", t);
      end
      chk(16'(exp_q.size()), 16'h0);
      chk(16'(exp_b_q.size()), 16'h0);
      end_of_test();
   end
endmodule
`default_nettype wire
